// file: core/uft_transmitter.sv
// uft_transmitter: format, enable and transmit path of the serial port
// assumes software-side strobes are synchronous to i_mclk
`timescale 1ns/1ps
module uft_transmitter
  import uft_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control
  input wire logic i_port_global_enable,
  input wire logic i_transmit_enable_set,
  input wire logic i_transmit_enable_clr,
  input wire logic i_receive_enable_set,
  input wire logic i_receive_enable_clr,
  input wire logic i_break_request_set,
  input wire logic i_break_request_clr,
  input wire logic i_transmit_interrupt_enable,
  input wire logic i_address_detect_enable,
  input wire uft_format_s i_format,
  input wire logic [15:0] i_baud_div,
  input wire logic [2:0] i_baud_fraction_field,
  // software access strobes
  input wire logic i_status_access,
  input wire logic i_data_write,
  input wire logic [7:0] i_data,
  // receive side flag events from the neighbouring receiver
  input wire uft_status_s i_rx_events,
  // pins
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  output logic o_tx_pin_oe,
  output logic o_rx_active,
  output logic o_rx_data,
  // status
  output logic o_transmit_enable,
  output logic o_receive_enable,
  output logic o_break_request,
  output uft_status_s o_status,
  output logic o_tx_irq
);
  uft_state_e state_reg, state_next;
  logic [8:0] hold_reg;
  logic hold_full_reg;
  logic [8:0] shift_reg;
  logic [3:0] bit_idx_reg;
  logic [15:0] baud_cnt_reg;
  logic [3:0] frac_acc_reg;
  logic stop_two_reg;
  logic par_bit_reg;
  logic tx_en_reg, rx_en_reg, brk_reg;
  logic armed_reg;
  logic tx_bit_reg;
  logic rx_s1_reg, rx_s2_reg;
  uft_status_s st_reg;

  // derived decodes
  wire logic disable_now = !i_port_global_enable;
  wire logic tx_abort = disable_now || !tx_en_reg;
  wire logic [3:0] frac_sum = {1'b0, frac_acc_reg[2:0]}
                              + {1'b0, i_baud_fraction_field};
  wire logic extra_clk = frac_sum[3];
  wire logic [15:0] bit_len = i_baud_div + {15'h0000, extra_clk};
  wire logic bit_end = (state_reg != ST_IDLE) &&
                       (baud_cnt_reg + 16'h0001 >= bit_len);
  wire logic [3:0] nbits = i_format.word_length_select ? BITS_9 : BITS_8;
  // parity takes the last word position, so fewer data bits are sent
  wire logic [3:0] data_bits = i_format.parity_enable ?
                               nbits - 4'h1 : nbits;
  wire logic [8:0] word_in = {i_format.transmit_ninth_bit, i_data};
  wire logic [8:0] par_mask = i_format.word_length_select ?
                              9'h0FF : 9'h07F;
  wire logic data_par = ^(hold_reg & par_mask);
  wire logic par_calc = (i_format.parity_type_select == PAR_MARK) ? 1'b1 :
                        (i_format.parity_type_select == PAR_SPACE) ? 1'b0 :
                        (i_format.parity_type_select == PAR_ODD) ?
                        ~data_par : data_par;
  wire logic write_ok = i_data_write && armed_reg &&
                        st_reg.transmit_empty_flag;
  wire logic can_load = (state_reg == ST_IDLE) && hold_full_reg &&
                        tx_en_reg;
  wire logic pins_on = i_port_global_enable && tx_en_reg;

  // sequencing of the frame
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (can_load) state_next = ST_START;
      ST_START: if (bit_end) state_next = ST_DATA;
      ST_DATA: if (bit_end && bit_idx_reg == data_bits - 4'h1) begin
        state_next = i_format.parity_enable ? ST_PAR : ST_STOP;
      end
      ST_PAR: if (bit_end) state_next = ST_STOP;
      ST_STOP: if (bit_end && !stop_two_reg) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || tx_abort) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bit timing with fractional stretch
  always_ff @(posedge i_mclk) begin
    if (i_rst || tx_abort || state_reg == ST_IDLE) begin
      baud_cnt_reg <= 16'h0000;
      frac_acc_reg <= 4'h0;
    end else if (bit_end) begin
      baud_cnt_reg <= 16'h0000;
      frac_acc_reg <= {1'b0, frac_sum[2:0]};
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end
  end

  // shift register and bit counter
  always_ff @(posedge i_mclk) begin
    if (i_rst || tx_abort) begin
      shift_reg <= 9'h000;
      bit_idx_reg <= 4'h0;
      stop_two_reg <= 1'b0;
      par_bit_reg <= 1'b0;
    end else if (can_load) begin
      shift_reg <= hold_reg;
      par_bit_reg <= par_calc;
      bit_idx_reg <= 4'h0;
      stop_two_reg <= i_format.stop_bit_count_select;
    end else if (bit_end) begin
      if (state_reg == ST_DATA) begin
        shift_reg <= {1'b0, shift_reg[8:1]};
        bit_idx_reg <= bit_idx_reg + 4'h1;
      end
      if (state_reg == ST_STOP) stop_two_reg <= 1'b0;
    end
  end

  // one-deep data buffer
  always_ff @(posedge i_mclk) begin
    if (i_rst || disable_now) begin
      hold_full_reg <= 1'b0;
      hold_reg <= 9'h000;
    end else if (write_ok) begin
      hold_reg <= word_in;
      hold_full_reg <= 1'b1;
    end else if (can_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // status access arms the following data write
  always_ff @(posedge i_mclk) begin
    if (i_rst || disable_now || i_data_write) begin
      armed_reg <= 1'b0;
    end else if (i_status_access) begin
      armed_reg <= 1'b1;
    end
  end

  // line level; mux is registered so the pin never glitches
  // an abort must not leave a stale data bit on the line
  always_ff @(posedge i_mclk) begin
    if (i_rst || tx_abort) begin
      tx_bit_reg <= 1'b1;
    end else begin
      unique case (state_next)
        ST_START: tx_bit_reg <= 1'b0;
        ST_DATA: tx_bit_reg <= (state_reg == ST_DATA && bit_end) ?
                               shift_reg[1] : shift_reg[0];
        ST_PAR: tx_bit_reg <= par_bit_reg;
        default: tx_bit_reg <= 1'b1;
      endcase
    end
  end

  // control bits cleared by disable, other settings untouched
  always_ff @(posedge i_mclk) begin
    if (i_rst || disable_now) begin
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      if (i_transmit_enable_set) tx_en_reg <= 1'b1;
      if (i_transmit_enable_clr) tx_en_reg <= 1'b0;
      if (i_receive_enable_set) rx_en_reg <= 1'b1;
      if (i_receive_enable_clr) rx_en_reg <= 1'b0;
      if (i_break_request_set) brk_reg <= 1'b1;
      if (i_break_request_clr) brk_reg <= 1'b0;
    end
  end

  // status flags; idle flag set wins over write clear, write clear wins over empty flag set
  wire logic frame_done = (state_reg == ST_STOP) && (state_next == ST_IDLE);
  wire logic hold_free = can_load || (hold_full_reg == 1'b0);
  always_ff @(posedge i_mclk) begin
    if (i_rst || disable_now) begin
      st_reg <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      if (write_ok) st_reg.transmit_empty_flag <= 1'b0;
      if (hold_free && !write_ok) st_reg.transmit_empty_flag <= 1'b1;
      if (write_ok) st_reg.transmit_idle_flag <= 1'b0;
      if (frame_done) st_reg.transmit_idle_flag <= 1'b1;
      st_reg.receive_idle_flag <= i_rx_events.receive_idle_flag;
      st_reg.receive_ready_flag <= i_rx_events.receive_ready_flag;
      st_reg.overrun_flag <= i_rx_events.overrun_flag;
      st_reg.framing_error_flag <= i_rx_events.framing_error_flag;
      st_reg.parity_error_flag <= i_rx_events.parity_error_flag;
      st_reg.noise_flag <= i_rx_events.noise_flag;
    end
  end

  // receive pin synchroniser for the shared-format receiver
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= i_rx_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // outputs
  assign o_tx_pin = tx_bit_reg;
  assign o_tx_pin_oe = pins_on;
  assign o_rx_active = i_port_global_enable && rx_en_reg;
  assign o_rx_data = rx_s2_reg;
  assign o_transmit_enable = tx_en_reg;
  assign o_receive_enable = rx_en_reg;
  assign o_break_request = brk_reg;
  assign o_status = st_reg;
  assign o_tx_irq = i_transmit_interrupt_enable &&
                    st_reg.transmit_empty_flag;
  // address detect enable is accepted but not used by the transmit path
  wire logic unused_addr = i_address_detect_enable;

  // checks
  property p_idle_high;
    @(posedge i_mclk) disable iff (i_rst)
      (state_reg == ST_IDLE && $past(state_reg) == ST_IDLE) |-> o_tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not high while idle");

  sequence s_start_taken;
    state_reg == ST_IDLE && can_load;
  endsequence
  property p_start_low;
    @(posedge i_mclk) disable iff (i_rst)
      s_start_taken |=> (state_reg == ST_START) && !o_tx_pin;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not driven low");

  property p_disable_flags;
    @(posedge i_mclk) disable iff (i_rst)
      disable_now |=> o_status.transmit_empty_flag &&
        o_status.transmit_idle_flag && !tx_en_reg && !hold_full_reg;
  endproperty
  a_disable_flags: assert property (p_disable_flags)
    else $error("disable did not reset flags");

  property p_write_blocked;
    @(posedge i_mclk) disable iff (i_rst || disable_now)
      (i_data_write && !st_reg.transmit_empty_flag && hold_full_reg)
        |=> $stable(hold_reg);
  endproperty
  a_write_blocked: assert property (p_write_blocked)
    else $error("write accepted while empty flag low");

  property p_abort;
    @(posedge i_mclk) disable iff (i_rst)
      !tx_en_reg |-> !o_tx_pin_oe ##1 state_reg == ST_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("transmitter not reset on disable");

  property p_idle_set;
    @(posedge i_mclk) disable iff (i_rst)
      frame_done |=> o_status.transmit_idle_flag;
  endproperty
  a_idle_set: assert property (p_idle_set)
    else $error("idle flag not set at frame end");

  property p_irq;
    @(posedge i_mclk) disable iff (i_rst)
      o_tx_irq |-> i_transmit_interrupt_enable &&
        o_status.transmit_empty_flag;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without empty flag");

  property p_load_after_stop;
    @(posedge i_mclk) disable iff (i_rst)
      (state_reg != ST_IDLE) |=> $stable(shift_reg) ||
        $past(bit_end) || state_reg == ST_IDLE;
  endproperty
  a_load_after_stop: assert property (p_load_after_stop)
    else $error("shift register reloaded mid frame");
endmodule : uft_transmitter

// file: core/uft_pkg.sv
// uft_pkg: shared constants and types for the frame transmitter core
// assumes one 50 MHz clock; control bits arrive as plain ports
//
// Behaviour
// - nrz frame: start, 8/9 data, 1/2 stop
// - even, odd, mark, space or no parity
// - power-on format is 8 data, N, 1
// - 16-bit baud divider, lsb first
// - one shared format and baud rate
// - pins active only when global and own enable set
// - serial output idles high
// - global disable frees pins, empties buffer
// - disable clears enables, errors; sets idle flags
// - global disable stop_bit_count_select frames; config kept
// - nine-bit mode takes msb from control
// - stop count only for transmitter
// - address mode: msb marks address frame
// - parity/address takes last word position
// - shift register loads after stop bit
// - send needs enable and loaded data
// - clearing transmit enable aborts and frees pin
// - writes ignored while empty flag low
// - empty flag set when buffer free
// - busy write held; idle write starts
// - idle flag set at frame end
// - integer divider plus 3-bit fractional carry
package uft_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
  localparam logic [2:0] BAUD_FRAC_RESET = 3'h0;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  typedef struct packed {
    logic word_length_select;
    logic parity_enable;
    logic [1:0] parity_type_select;
    logic stop_bit_count_select;
    logic transmit_ninth_bit;
  } uft_format_s;

  localparam uft_format_s FORMAT_RESET = '{1'b0, 1'b0, PAR_EVEN, 1'b0, 1'b0};

  typedef struct packed {
    logic transmit_empty_flag;
    logic transmit_idle_flag;
    logic receive_idle_flag;
    logic receive_ready_flag;
    logic overrun_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic noise_flag;
  } uft_status_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PAR = 5'b01000,
    ST_STOP = 5'b10000
  } uft_state_e;
endpackage : uft_pkg

// file: testbench/uft_remote.sv
// uft_remote: far-end serial receiver sampling the transmit line
// assumes a bit time of DIV clocks and no fractional stretch
`timescale 1ns/1ps
module uft_remote #(
  parameter int DIV = 8
) (
  // line side
  input wire logic i_mclk,
  input wire logic i_line,
  input wire logic i_oe,
  input wire logic [3:0] i_nbits,
  // capture
  output logic [11:0] o_bits,
  output logic o_rx_line,
  output int o_frames
);
  initial begin
    o_bits = 12'h000;
    o_frames = 0;
    o_rx_line = 1'b1;
    forever begin
      @(posedge i_mclk);
      // an undriven pin is not a start bit
      if (i_oe && !i_line) begin
        o_bits = 12'h000;
        repeat (DIV / 2) @(posedge i_mclk);
        for (int i = 0; i < i_nbits; i++) begin
          repeat (DIV) @(posedge i_mclk);
          o_bits[i] = i_line;
        end
        o_frames++;
      end
    end
  end
endmodule : uft_remote

// file: testbench/uft_transmitter_bench.sv
// uft_transmitter_bench: self-checking bench for the transmit path
// assumes the remote model decodes frames at a fixed divider
`timescale 1ns/1ps
module uft_transmitter_bench
  import uft_pkg::*;
;
  localparam int DIV = 8;
  logic i_mclk, i_rst, en, tx_set, tx_clr, rx_set, brk_set, irq_en;
  logic stat, wr, rx_line, tx_pin, tx_oe, rx_act, txe, rxe, brk, irq;
  logic [7:0] data;
  logic [15:0] div;
  logic [11:0] bits;
  logic [3:0] nbits;
  uft_format_s fmt;
  uft_status_s st;
  int frames, n_mismatch, n_compared;

  uft_transmitter uft_transmitter_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_port_global_enable(en),
    .i_transmit_enable_set(tx_set), .i_transmit_enable_clr(tx_clr),
    .i_receive_enable_set(rx_set), .i_receive_enable_clr(1'b0),
    .i_break_request_set(brk_set), .i_break_request_clr(1'b0),
    .i_transmit_interrupt_enable(irq_en), .i_address_detect_enable(1'b0),
    .i_format(fmt), .i_baud_div(div), .i_baud_fraction_field(3'h0),
    .i_status_access(stat), .i_data_write(wr), .i_data(data),
    .i_rx_events('0), .i_rx_pin(rx_line), .o_tx_pin(tx_pin),
    .o_tx_pin_oe(tx_oe), .o_rx_active(rx_act), .o_rx_data(),
    .o_transmit_enable(txe), .o_receive_enable(rxe),
    .o_break_request(brk), .o_status(st), .o_tx_irq(irq));

  uft_remote #(.DIV(DIV)) uft_remote_i (
    .i_mclk(i_mclk), .i_line(tx_pin), .i_oe(tx_oe), .i_nbits(nbits),
    .o_bits(bits), .o_rx_line(rx_line), .o_frames(frames));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic end_sim;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, msg);
      n_mismatch++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick

  // status access then write, as software must
  task automatic send(input logic [7:0] d);
    stat <= 1'b1;
    tick(1);
    stat <= 1'b0;
    wr <= 1'b1;
    data <= d;
    tick(1);
    wr <= 1'b0;
  endtask : send

  function automatic logic [11:0] exp_frame(input logic [7:0] d,
      input uft_format_s f, output logic [3:0] n);
    logic [8:0] w;
    int nd;
    logic p;
    nd = f.word_length_select ? 9 : 8;
    w = {f.transmit_ninth_bit, d};
    if (f.parity_enable) begin
      nd = nd - 1;
      w = w & ~(9'h1ff << nd);
      case (f.parity_type_select)
        PAR_EVEN: p = ^w;
        PAR_ODD: p = ~^w;
        PAR_MARK: p = 1'b1;
        default: p = 1'b0;
      endcase
      w[nd] = p;
      nd = nd + 1;
    end
    exp_frame = 12'h000;
    n = 4'(nd + (f.stop_bit_count_select ? 2 : 1));
    for (int i = 0; i < n; i++) exp_frame[i] = (i < nd) ? w[i] : 1'b1;
  endfunction : exp_frame

  task automatic wait_frame(input int base);
    for (int i = 0; i < 400 && frames == base; i++) tick(1);
    chk(frames != base, "no frame seen");
  endtask : wait_frame

  task automatic frame(input logic [7:0] d, input uft_format_s f);
    logic [11:0] e;
    logic [3:0] n;
    int base;
    e = exp_frame(d, f, n);
    fmt <= f;
    nbits <= n;
    base = frames;
    tick(1);
    send(d);
    wait_frame(base);
    chk(bits === e, "frame bits");
    tick(DIV);
    chk(st.transmit_idle_flag === 1'b1, "idle flag");
    chk(tx_pin === 1'b1, "line not high");
  endtask : frame

  task automatic t_reset;
    chk(st.transmit_empty_flag === 1'b1, "empty flag");
    chk(st.receive_idle_flag === 1'b1, "rx idle");
    chk(tx_pin === 1'b1 && tx_oe === 1'b0, "reset pin");
  endtask : t_reset

  task automatic t_enable;
    en <= 1'b1;
    tx_set <= 1'b1;
    rx_set <= 1'b1;
    tick(1);
    tx_set <= 1'b0;
    rx_set <= 1'b0;
    tick(2);
    chk(tx_oe === 1'b1 && rx_act === 1'b1, "pins");
  endtask : t_enable

  task automatic t_parity;
    uft_format_s f;
    f = FORMAT_RESET;
    f.parity_enable = 1'b1;
    for (int t = 0; t < 4; t++) begin
      f.parity_type_select = 2'(t);
      frame(8'h6b, f);
    end
    f.word_length_select = 1'b1;
    frame(8'hd3, f);
  endtask : t_parity

  task automatic t_refused;
    int base;
    base = frames;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(150);
    chk(frames == base, "unarmed write sent");
  endtask : t_refused

  task automatic t_b2b;
    logic [3:0] n;
    int base;
    fmt <= FORMAT_RESET;
    nbits <= 4'h9;
    base = frames;
    tick(1);
    send(8'h81);
    tick(3);
    chk(st.transmit_empty_flag === 1'b1, "idle write");
    send(8'h7e);
    wait_frame(base);
    chk(bits === exp_frame(8'h81, FORMAT_RESET, n), "first");
    chk(st.transmit_empty_flag === 1'b0, "held");
    base = frames;
    wait_frame(base);
    chk(bits === exp_frame(8'h7e, FORMAT_RESET, n), "second");
  endtask : t_b2b

  task automatic t_pre_write;
    int base;
    tx_clr <= 1'b1;
    tick(1);
    tx_clr <= 1'b0;
    base = frames;
    send(8'hc3);
    tick(40);
    chk(tx_oe === 1'b0 && frames == base, "sent early");
    tx_set <= 1'b1;
    tick(1);
    tx_set <= 1'b0;
    wait_frame(base);
    chk(bits[8:0] === 9'h1c3, "late frame");
  endtask : t_pre_write

  task automatic t_abort(input logic glob);
    brk_set <= 1'b1;
    irq_en <= 1'b1;
    send(8'h00);
    brk_set <= 1'b0;
    tick(30);
    en <= !glob;
    tx_clr <= !glob;
    tick(1);
    tx_clr <= 1'b0;
    tick(2);
    chk(tx_oe === 1'b0 && txe === 1'b0, "abort");
    if (glob) begin
      chk(rx_act === 1'b0 && rxe === 1'b0, "rx off");
      chk(brk === 1'b0, "break kept");
      chk(st === 8'he0, "flags");
      chk(irq === 1'b1, "irq");
    end
    tick(150);
    en <= 1'b1;
    t_enable;
    frame(8'h99, fmt);
  endtask : t_abort

  initial begin
    i_rst = 1'b1;
    {en, tx_set, tx_clr, rx_set, brk_set, irq_en, stat, wr} = 8'h00;
    data = 8'h00;
    div = 16'(DIV);
    nbits = 4'h9;
    fmt = FORMAT_RESET;
    tick(4);
    i_rst <= 1'b0;
    tick(1);
    t_reset;
    t_enable;
    frame(8'h5a, FORMAT_RESET);
    t_parity;
    frame(8'h3c, '{1'b1, 1'b0, PAR_EVEN, 1'b1, 1'b1});
    t_refused;
    t_b2b;
    t_pre_write;
    t_abort(1'b0);
    t_abort(1'b1);
    end_sim;
  end

  initial begin
    tick(20000);
    n_mismatch++;
    end_sim;
  end
endmodule : uft_transmitter_bench
